// file: hw/bac_pkg.sv
// package for the burst and auto-restart control unit
`default_nettype none
package bac_pkg;
   localparam int CLK_HZ         = 40_000_000;
   localparam int BLANK_MS       = 20;
   localparam int SPIKE_US       = 30;
   localparam int OVP_US         = 120;
   localparam int SS_STEP_US     = 600;
   localparam int SS_STEPS       = 32;
   localparam int BLANK_CYC      = (CLK_HZ / 1000) * BLANK_MS;
   localparam int SPIKE_CYC      = (CLK_HZ / 1_000_000) * SPIKE_US;
   localparam int OVP_CYC        = (CLK_HZ / 1_000_000) * OVP_US;
   localparam int SS_STEP_CYC    = (CLK_HZ / 1_000_000) * SS_STEP_US;
   localparam int CNT_W          = 24;
   localparam logic [5:0] SS_RESET = 6'h00;
   localparam logic [15:0] WB_ID   = 16'hB0C1; // arbitrary identification value
   localparam logic [3:0] A_CTRL   = 4'h0;
   localparam logic [3:0] A_STAT   = 4'h4;
   localparam logic [3:0] A_CAUSE  = 4'h8;
   localparam logic [3:0] A_ID     = 4'hC;
   localparam logic [1:0] CTRL_RESET = 2'h0;

   typedef enum {ST_OFF, ST_SOFT, ST_NORMAL, ST_BURST, ST_RESTART} bac_state_t;

   // comparator inputs travelling together
   typedef struct packed {
      logic fbLow;        // feedback below 1.35 V
      logic fbHigh;       // feedback above 4.0 V
      logic burstWake;    // feedback above 3.5 V
      logic burstSleep;   // feedback at/below 3.05 V
      logic blankPinHigh; // blanking pin above 4.0 V
      logic vccOvp;       // supply above 25.5 V
      logic overTemp;
      logic vccUnder;     // supply at turn-off threshold
      logic vccOn;        // supply at turn-on threshold
      logic shortOpto;
      logic extRestart;
   } bac_cmp_t;
endpackage : bac_pkg
`default_nettype wire

// file: hw/bac_control.sv
// burst mode and auto-restart control unit with wishbone status access
// Function
// - 20 ms blanking precedes burst entry and overload auto-restart.
// - Blanking counter held at zero normally, counts while feedback below 1.35 V.
// - Burst entered only if counter hits 20 ms with feedback still low.
// - Burst entry sets burst flag and turns internal bias off.
// - Startup cell kept off during burst.
// - In burst, feedback above 3.5 V re-enables bias and switching.
// - Burst selects the reduced 0.34 V current limit.
// - In burst, feedback at 3.05 V turns bias off again.
// - Feedback above 4.0 V in burst leaves burst, restores full limit.
// - Burst uses fixed blanking; overload uses fixed plus extendable blanking.
// - Feedback above 4.0 V counts blanking; at 20 ms clamp switch released.
// - Auto-restart needs feedback-high and pin-high for 30 us spike blanking.
// - Released pin charges 0.9 V to 4.0 V; its comparator gates restart.
// - Overvoltage, temperature, undervoltage, short opto, external request restart at once.
// - Auto-restart stops switching until supply reaches turn-off threshold.
// - At turn-off enable startup cell; at turn-on disable it and power up.
// - After restart soft start runs, then fault rechecked.
// - Soft start: 32 steps, one per 600 us, done within 20 ms.
// - Supply above 25.5 V for 120 us restarts, ignored in burst.
`default_nettype none
module bac_control
   import bac_pkg::*;
#(
   parameter int BLANK_CYCLES = BLANK_CYC,   // 20 ms blanking
   parameter int SPIKE_CYCLES = SPIKE_CYC,   // 30 us spike blanking
   parameter int OVP_CYCLES   = OVP_CYC,     // 120 us overvoltage filter
   parameter int STEP_CYCLES  = SS_STEP_CYC  // 600 us soft start step
) (
   input  wire logic        clk,          // 40 MHz clock
   input  wire logic        resetn,       // synchronous reset, active low
   input  wire bac_cmp_t    cmpIn,        // raw comparator outputs
   output logic             gateEnable,   // permits the gate-drive latch
   output logic             biasOn,       // internal bias enable
   output logic             startupOn,    // startup cell enable
   output logic             reducedLimit, // selects 0.34 V current limit
   output logic             clampRelease, // opens the blanking pin clamp
   output logic             burstFlag,    // burst mode active
   output logic [5:0]       softLevel,    // soft start duty step
   input  wire logic [3:0]  wbAdr,        // wishbone byte address
   input  wire logic [31:0] wbDatW,       // write data
   input  wire logic [3:0]  wbSel,        // byte selects
   input  wire logic        wbWe,         // write enable
   input  wire logic        wbCyc,        // cycle
   input  wire logic        wbStb,        // strobe
   output logic [31:0]      wbDatR,       // read data
   output logic             wbAck         // acknowledge
);
   bac_cmp_t   s1_reg, s2_reg;
   bac_state_t state_reg, state_next;
   logic [CNT_W-1:0] blank_reg, blank_next;
   logic [CNT_W-1:0] spike_reg, spike_next;
   logic [CNT_W-1:0] ovp_reg, ovp_next;
   logic [CNT_W-1:0] step_reg, step_next;
   logic [5:0]       soft_reg, soft_next;
   logic             bias_reg, bias_next;
   logic [1:0]       ctrl_reg;
   logic [7:0]       cause_reg, cause_next;
   logic [31:0]      rd_reg;
   logic             ack_reg;

   // only the second stage is ever read
   always_ff @(posedge clk) begin
      s1_reg <= cmpIn;
      s2_reg <= s1_reg;
   end

   wire blankDone  = (blank_reg >= CNT_W'(BLANK_CYCLES));
   wire spikeDone  = (spike_reg >= CNT_W'(SPIKE_CYCLES));
   wire ovpFault   = (ovp_reg >= CNT_W'(OVP_CYCLES));
   wire softDone   = (soft_reg == 6'(SS_STEPS));
   wire inBurst    = (state_reg == ST_BURST);
   wire running    = (state_reg == ST_SOFT) || (state_reg == ST_NORMAL);
   // ctrl bit 0 masks the external request, bit 1 forces a restart for service
   wire extReq     = s2_reg.extRestart & ~ctrl_reg[0];
   wire fastFault  = ovpFault | s2_reg.overTemp | s2_reg.vccUnder
                   | s2_reg.shortOpto | extReq | ctrl_reg[1];
   wire andGate    = s2_reg.fbHigh & s2_reg.blankPinHigh & blankDone;
   wire slowFault  = andGate & spikeDone;
   wire countLow   = (state_reg == ST_NORMAL) & s2_reg.fbLow;
   wire countHigh  = running & s2_reg.fbHigh;

   // blanking counter: counts only while a qualifying level persists
   always_comb begin
      blank_next = '0;
      if ((countLow | countHigh) & ~blankDone) begin
         blank_next = blank_reg + CNT_W'(1);
      end else if (countLow | countHigh) begin
         blank_next = blank_reg;
      end
      if (state_reg == ST_RESTART) begin
         blank_next = '0;
      end
   end

   always_comb begin
      spike_next = '0;
      if (andGate && running) begin
         spike_next = spikeDone ? spike_reg : spike_reg + CNT_W'(1);
      end
   end

   // overvoltage filter, disabled in burst
   always_comb begin
      ovp_next = '0;
      if (s2_reg.vccOvp && !inBurst && state_reg != ST_RESTART) begin
         ovp_next = ovpFault ? ovp_reg : ovp_reg + CNT_W'(1);
      end
   end

   // soft start stepping
   always_comb begin
      step_next = '0;
      soft_next = soft_reg;
      if (state_reg == ST_SOFT && !softDone) begin
         if (step_reg >= CNT_W'(STEP_CYCLES - 1)) begin
            soft_next = soft_reg + 6'h01;
         end else begin
            step_next = step_reg + CNT_W'(1);
         end
      end else if (state_reg != ST_SOFT && state_reg != ST_NORMAL
                   && state_reg != ST_BURST) begin
         soft_next = SS_RESET;
      end
   end

   always_comb begin
      state_next = state_reg;
      bias_next  = bias_reg;
      cause_next = cause_reg;
      case (state_reg)
         ST_OFF: begin
            bias_next = 1'b0;
            if (s2_reg.vccOn) begin
               state_next = ST_SOFT;
               bias_next  = 1'b1;
            end
         end
         ST_SOFT: begin
            if (fastFault || slowFault) begin
               state_next = ST_RESTART;
            end else if (softDone) begin
               state_next = ST_NORMAL;
            end
         end
         ST_NORMAL: begin
            if (fastFault || slowFault) begin
               state_next = ST_RESTART;
            end else if (blankDone && s2_reg.fbLow) begin
               state_next = ST_BURST;
               bias_next  = 1'b0;
            end
         end
         ST_BURST: begin
            if (fastFault) begin
               state_next = ST_RESTART;
            end else if (s2_reg.fbHigh) begin
               state_next = ST_NORMAL;
               bias_next  = 1'b1;
            end else if (s2_reg.burstWake) begin
               bias_next = 1'b1;
            end else if (s2_reg.burstSleep) begin
               bias_next = 1'b0;
            end
         end
         ST_RESTART: begin
            bias_next = 1'b0;
            if (s2_reg.vccUnder) begin
               state_next = ST_OFF;
            end
         end
         default: begin
            state_next = ST_OFF;
            bias_next  = 1'b0;
         end
      endcase
      if (state_next == ST_RESTART && state_reg != ST_RESTART) begin
         cause_next = {1'b0, slowFault, ovpFault, s2_reg.overTemp, s2_reg.vccUnder,
                       s2_reg.shortOpto, extReq, ctrl_reg[1]};
      end
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         state_reg <= ST_OFF;
         blank_reg <= '0;
         spike_reg <= '0;
         ovp_reg   <= '0;
         step_reg  <= '0;
         soft_reg  <= SS_RESET;
         bias_reg  <= 1'b0;
         cause_reg <= 8'h00;
      end else begin
         state_reg <= state_next;
         blank_reg <= blank_next;
         spike_reg <= spike_next;
         ovp_reg   <= ovp_next;
         step_reg  <= step_next;
         soft_reg  <= soft_next;
         bias_reg  <= bias_next;
         cause_reg <= cause_next;
      end
   end

   // registered outputs derived from state
   always_ff @(posedge clk) begin
      if (!resetn) begin
         gateEnable   <= 1'b0;
         biasOn       <= 1'b0;
         startupOn    <= 1'b1;
         reducedLimit <= 1'b0;
         clampRelease <= 1'b0;
         burstFlag    <= 1'b0;
         softLevel    <= SS_RESET;
      end else begin
         gateEnable   <= bias_next & (state_next != ST_RESTART)
                       & (state_next != ST_OFF);
         biasOn       <= bias_next;
         startupOn    <= (state_next == ST_OFF);
         reducedLimit <= (state_next == ST_BURST);
         clampRelease <= running & s2_reg.fbHigh & blankDone;
         burstFlag    <= (state_next == ST_BURST);
         softLevel    <= soft_next;
      end
   end

   // wishbone slave: one wait state, ack for a single cycle
   wire        wbReq   = wbCyc & wbStb & ~ack_reg;
   wire [31:0] stat    = {16'h0000, 2'b00, soft_reg, 1'b0, burstFlag, biasOn,
                          startupOn, reducedLimit, clampRelease, gateEnable,
                          state_reg == ST_RESTART};
   wire [31:0] rdMux   = (wbAdr == A_CTRL)  ? {30'h0, ctrl_reg} :
                         (wbAdr == A_STAT)  ? stat :
                         (wbAdr == A_CAUSE) ? {24'h0, cause_reg} :
                         (wbAdr == A_ID)    ? {16'h0, WB_ID} : 32'h0000_0000;

   always_ff @(posedge clk) begin
      if (!resetn) begin
         ack_reg  <= 1'b0;
         rd_reg   <= 32'h0000_0000;
         ctrl_reg <= CTRL_RESET;
      end else begin
         ack_reg <= wbReq;
         rd_reg  <= rdMux;
         // write lands at the edge where the master samples ack high
         if (ack_reg && wbCyc && wbStb && wbWe && wbAdr == A_CTRL && wbSel[0]) begin
            ctrl_reg <= wbDatW[1:0];
         end
      end
   end

   assign wbAck  = ack_reg;
   assign wbDatR = rd_reg;
endmodule : bac_control
`default_nettype wire

// file: tb/bac_control_properties.sv
// assertion checker for the burst and auto-restart control unit
`default_nettype none
module bac_control_properties
   import bac_pkg::*;
#(
   parameter int BLANK_CYCLES = BLANK_CYC // blanking length in cycles
) (
   input wire logic     clk,          // clock
   input wire logic     resetn,       // sync reset, low
   input wire bac_cmp_t cmpIn,        // comparators
   input wire logic     gateEnable,   // switching allowed
   input wire logic     biasOn,       // bias on
   input wire logic     startupOn,    // startup cell
   input wire logic     reducedLimit, // reduced limit
   input wire logic     clampRelease, // clamp open
   input wire logic     burstFlag     // burst mode
);
   logic [23:0] loCnt;
   logic [23:0] hiCnt;
   // raw run lengths; the design lags them, so they only bound entry from below
   always_ff @(posedge clk) begin
      loCnt <= (!resetn || !cmpIn.fbLow) ? '0 : loCnt + 24'h1;
      hiCnt <= (!resetn || !cmpIn.fbHigh) ? '0 : hiCnt + 24'h1;
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);
   property p_burst_limit; burstFlag |-> reducedLimit; endproperty
   a_burst_limit: assert property (p_burst_limit) else $error("limit not reduced");
   property p_burst_nostart; burstFlag |-> !startupOn; endproperty
   a_burst_nostart: assert property (p_burst_nostart) else $error("startup on in burst");
   property p_entry_bias; $rose(burstFlag) |-> !biasOn; endproperty
   a_entry_bias: assert property (p_entry_bias) else $error("bias on at entry");
   property p_entry_blank; $rose(burstFlag) |-> loCnt >= BLANK_CYCLES; endproperty
   a_entry_blank: assert property (p_entry_blank) else $error("burst too early");
   property p_clamp_blank; $rose(clampRelease) |-> hiCnt >= BLANK_CYCLES; endproperty
   a_clamp_blank: assert property (p_clamp_blank) else $error("clamp too early");
   property p_gate_bias; gateEnable |-> biasOn; endproperty
   a_gate_bias: assert property (p_gate_bias) else $error("switching without bias");
   property p_wake;
      (burstFlag && cmpIn.burstWake && !cmpIn.burstSleep && !cmpIn.fbHigh) [*5] |-> biasOn;
   endproperty
   a_wake: assert property (p_wake) else $error("no wake");
   property p_sleep;
      (burstFlag && cmpIn.burstSleep && !cmpIn.burstWake && !cmpIn.fbHigh) [*5] |-> !biasOn;
   endproperty
   a_sleep: assert property (p_sleep) else $error("no sleep");
   property p_exit; burstFlag && cmpIn.fbHigh |-> ##[1:5] !burstFlag && !reducedLimit; endproperty
   a_exit: assert property (p_exit) else $error("burst not left");
   property p_fast; cmpIn.overTemp || cmpIn.shortOpto |-> ##[1:5] !gateEnable; endproperty
   a_fast: assert property (p_fast) else $error("fast fault ignored");
endmodule : bac_control_properties
`default_nettype wire

// file: tb/bac_analog_model.sv
// behavioural model of blanking pin and supply comparators
`default_nettype none
module bac_analog_model #(
   parameter int CHARGE = 8 // extension capacitor charge cycles
) (
   input  wire logic clk,          // clock
   input  wire logic clampRelease, // clamp switch open
   input  wire logic startupOn,    // startup cell charging
   input  wire logic biasOn,       // chip self supplied
   input  wire logic burstFlag,    // supply held by application
   output logic      blankPinHigh, // pin at 4.0 V
   output logic      vccUnder,     // turn-off threshold
   output logic      vccOn         // turn-on threshold
);
   int pin = 0;
   int vcc = 10;
   always @(posedge clk) begin
      pin <= clampRelease ? pin + 1 : 0;
      if (startupOn) vcc <= (vcc < 20) ? vcc + 1 : 20;
      else if (!biasOn && !burstFlag) vcc <= (vcc > 0) ? vcc - 1 : 0;
   end
   assign blankPinHigh = pin >= CHARGE;
   assign vccUnder = vcc == 0;
   assign vccOn = vcc >= 20;
endmodule : bac_analog_model
`default_nettype wire

// file: tb/bac_control_tb.sv
// self-checking bench for the burst and auto-restart control unit
`default_nettype none
module bac_control_tb;
   timeunit 1ns;
   timeprecision 100ps;
   import bac_pkg::*;
   localparam int BLANK = 20;
   localparam int STEP = 5;
   localparam int SPK = 4;
   localparam int CHG = 8;
   typedef struct {bac_cmp_t f; int hold; logic off; logic [31:0] cause;} bac_row_t;
   bac_row_t    rows [5] = '{'{'{overTemp:1'b1, default:1'b0}, 2, 1'b1, 32'h10},
      '{'{shortOpto:1'b1, default:1'b0}, 2, 1'b1, 32'h4},
      '{'{extRestart:1'b1, default:1'b0}, 2, 1'b1, 32'h2},
      '{'{vccOvp:1'b1, default:1'b0}, 3, 1'b0, 32'h0},
      '{'{vccOvp:1'b1, default:1'b0}, 12, 1'b1, 32'h20}};
   logic        clk = 0, resetn = 0, wbWe = 0, wbCyc = 0, wbStb = 0;
   logic        gateEnable, biasOn, startupOn, reducedLimit, clampRelease, burstFlag;
   logic        wbAck, pinHi, vUnder, vOn;
   logic [5:0]  softLevel;
   logic [3:0]  wbAdr = 4'h0, wbSel = 4'h0;
   logic [31:0] wbDatW = 32'h0, wbDatR, rd;
   bac_cmp_t    drv = '0, cmpIn;
   int          errors = 0, checks = 0, cyc = 0, n;
   always_comb begin
      cmpIn = drv;
      cmpIn.blankPinHigh = pinHi;
      cmpIn.vccUnder = vUnder;
      cmpIn.vccOn = vOn;
   end
   bac_control #(.BLANK_CYCLES(BLANK), .SPIKE_CYCLES(SPK), .OVP_CYCLES(6), .STEP_CYCLES(STEP))
   dut (.clk(clk), .resetn(resetn), .cmpIn(cmpIn), .gateEnable(gateEnable), .biasOn(biasOn),
      .startupOn(startupOn), .reducedLimit(reducedLimit), .clampRelease(clampRelease),
      .burstFlag(burstFlag), .softLevel(softLevel), .wbAdr(wbAdr), .wbDatW(wbDatW),
      .wbSel(wbSel), .wbWe(wbWe), .wbCyc(wbCyc), .wbStb(wbStb), .wbDatR(wbDatR), .wbAck(wbAck));
   bac_analog_model #(.CHARGE(CHG)) partner (.clk(clk), .clampRelease(clampRelease),
      .startupOn(startupOn), .biasOn(biasOn), .burstFlag(burstFlag),
      .blankPinHigh(pinHi), .vccUnder(vUnder), .vccOn(vOn));
   initial forever #12.5 clk = ~clk;
   task automatic tally_and_finish;
      $display("checks %0d errors %0d", checks, errors);
      if (errors == 0 && checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : tally_and_finish
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 12000) begin
         errors++;
         tally_and_finish();
      end
   end
   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      checks++;
      if (got !== exp) begin
         errors++;
         $display("[ERR] %s expected %0h seen %0h", nm, exp, got);
      end
   endtask : chk
   task automatic tick(input int k);
      repeat (k) @(posedge clk);
   endtask : tick
   // ack and data are taken at the edge that samples ack high
   task automatic wb(input logic [3:0] a, input logic we, input logic [31:0] d);
      @(posedge clk);
      {wbAdr, wbWe, wbDatW, wbSel, wbCyc, wbStb} <= {a, we, d, 4'hF, 2'h3};
      do @(posedge clk); while (wbAck !== 1'b1);
      rd = wbDatR;
      {wbCyc, wbStb, wbWe} <= 3'h0;
   endtask : wb
   task automatic up;
      for (n = 0; n < 3000 && !(gateEnable === 1'b1 && softLevel === 6'h20); n++) @(posedge clk);
   endtask : up
   initial begin
      tick(4);
      chk("reset startup", 1, startupOn);
      chk("reset gate", 0, gateEnable);
      resetn <= 1'b1;
      up();
      chk("soft time", 1, n >= 32 * STEP && n < 3000);
      chk("startup off", 0, startupOn);
      wb(A_STAT, 1'b0, 32'h0);
      chk("status", 32'h2022, rd);
      foreach (rows[i]) begin
         drv <= rows[i].f;
         tick(rows[i].hold);
         drv <= '0;
         tick(5);
         chk("gate", !rows[i].off, gateEnable);
         if (rows[i].off) begin
            wb(A_CAUSE, 1'b0, 32'h0);
            chk("cause", rows[i].cause, rd);
            up();
            chk("recover", 1, n < 3000);
         end
         $display("row %0d done", i);
      end
      drv.fbLow <= 1'b1;
      tick(BLANK - 8);
      drv.fbLow <= 1'b0;
      tick(8);
      chk("early burst", 0, burstFlag);
      drv.fbLow <= 1'b1;
      tick(BLANK + 8);
      chk("burst", 1, burstFlag);
      chk("limit", 1, reducedLimit);
      chk("bias", 0, biasOn);
      chk("startup", 0, startupOn);
      drv.vccOvp <= 1'b1;
      tick(12);
      drv.vccOvp <= 1'b0;
      tick(5);
      chk("ovp in burst", 1, burstFlag);
      drv <= '{burstWake:1'b1, default:1'b0};
      tick(6);
      chk("wake", 1, biasOn & gateEnable);
      drv <= '{burstSleep:1'b1, default:1'b0};
      tick(6);
      chk("sleep", 0, biasOn);
      drv <= '{fbHigh:1'b1, default:1'b0};
      tick(3);
      drv <= '0;
      tick(6);
      chk("exit", 0, burstFlag | reducedLimit);
      $display("burst done");
      drv.fbHigh <= 1'b1;
      for (n = 0; n < 100 && clampRelease !== 1'b1; n++) @(posedge clk);
      chk("clamp time", 1, n >= BLANK && n < 100);
      for (n = 0; n < 100 && gateEnable !== 1'b0; n++) @(posedge clk);
      chk("spike time", 1, n >= CHG + SPK && n < 100);
      drv <= '0;
      chk("flag clear", 0, burstFlag);
      wb(A_CAUSE, 1'b0, 32'h0);
      chk("overload", 32'h40, rd);
      up();
      chk("recover", 1, n < 3000);
      wb(A_ID, 1'b0, 32'h0);
      chk("id", {16'h0, WB_ID}, rd);
      wb(4'h2, 1'b0, 32'h0);
      chk("unmapped", 32'h0, rd);
      wb(A_CTRL, 1'b1, 32'h2);
      tick(6);
      chk("forced off", 0, gateEnable);
      wb(A_CTRL, 1'b1, 32'h0);
      up();
      chk("after force", 1, n < 3000);
      $display("bus done");
      tally_and_finish();
   end
endmodule : bac_control_tb
bind bac_control bac_control_properties #(.BLANK_CYCLES(BLANK_CYCLES)) props (.clk(clk),
   .resetn(resetn), .cmpIn(cmpIn), .gateEnable(gateEnable), .biasOn(biasOn),
   .startupOn(startupOn), .reducedLimit(reducedLimit), .clampRelease(clampRelease),
   .burstFlag(burstFlag));
`default_nettype wire
